// >>> verilog/pipf_defs.svh
// register offsets, reset values, masks and timing counts for the port block
`ifndef PIPF_DEFS_SVH
`define PIPF_DEFS_SVH

// ==========================================
// register byte offsets
`define PIPF_OFS_INPUT_LEVEL 12'h000
`define PIPF_OFS_PULLUP_CTRL 12'h004
`define PIPF_OFS_OUTPUT_LATCH 12'h008
`define PIPF_OFS_DIRECTION 12'h00C
`define PIPF_OFS_FILTER_ENABLE 12'h010
`define PIPF_OFS_FILTER_EXPECT 12'h014
`define PIPF_OFS_SAMPLE_PERIOD 12'h018

// ==========================================
// reset values
`define PIPF_RST_PULLUP_CTRL 8'h00
`define PIPF_RST_OUTPUT_LATCH 8'h00
`define PIPF_RST_DIRECTION 8'h00
`define PIPF_RST_FILTER_ENABLE 8'h00
`define PIPF_RST_FILTER_EXPECT 8'h00
`define PIPF_RST_SAMPLE_PERIOD 3'h0

// ==========================================
// implemented-bit masks
`define PIPF_MASK_FULL 8'hFF
`define PIPF_MASK_TOP5_RSVD 8'h07
`define PIPF_MASK_TOP3_RSVD 8'h1F
`define PIPF_MASK_TOP2_RSVD 8'h3F
`define PIPF_MASK_TOP1_RSVD 8'h7F

// ==========================================
// sampling divider: clock divided by 2, 32, 8192 ... 262144, held as divisor minus one
`define PIPF_PRESCALE_WIDTH 18
`define PIPF_DIV_M1_0 18'h00001
`define PIPF_DIV_M1_1 18'h0001F
`define PIPF_DIV_M1_2 18'h01FFF
`define PIPF_DIV_M1_3 18'h03FFF
`define PIPF_DIV_M1_4 18'h07FFF
`define PIPF_DIV_M1_5 18'h0FFFF
`define PIPF_DIV_M1_6 18'h1FFFF
`define PIPF_DIV_M1_7 18'h3FFFF

`endif

// >>> verilog/pipf_pkg.sv
// types shared by the port block
package pipf_pkg;

   // ==========================================
   // which port of the family an instance stands for
   typedef enum {
      PIPF_PORT_1, PIPF_PORT_2, PIPF_PORT_3, PIPF_PORT_4, PIPF_PORT_5, PIPF_PORT_6, PIPF_PORT_7,
      PIPF_PORT_8, PIPF_PORT_9, PIPF_PORT_A, PIPF_PORT_B, PIPF_PORT_C, PIPF_PORT_D, PIPF_PORT_E,
      PIPF_PORT_F, PIPF_PORT_G, PIPF_PORT_H
   } pipf_port_t;

   // ==========================================
   // pull-up behaviour families
   typedef enum {
      PIPF_PU_NONE, PIPF_PU_PLAIN, PIPF_PU_COMPAT
   } pipf_pullup_kind_t;

endpackage : pipf_pkg

// >>> verilog/pipf_port.sv
// one 8-bit general-purpose port: pin level, pull-up control, output latch, noise canceller
`timescale 1ns/100ps
`include "pipf_defs.svh"

module pipf_port
   import pipf_pkg::*;
#(
   parameter pipf_port_t PORT_ID = PIPF_PORT_C
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic portControlTwo,
   input wire logic [7:0] pinIn,
   output logic [7:0] pinOut,
   output logic [7:0] pinOe,
   output logic [7:0] pullupOn
);

   // ==========================================
   // per-port structure
   function automatic logic [7:0] levelMask(input pipf_port_t p);
      if (p == PIPF_PORT_5)
         return `PIPF_MASK_TOP5_RSVD;
      else if (p == PIPF_PORT_8)
         return `PIPF_MASK_TOP1_RSVD;
      else if (p == PIPF_PORT_E)
         return `PIPF_MASK_TOP3_RSVD;
      else if (p == PIPF_PORT_H)
         return `PIPF_MASK_TOP2_RSVD;
      else
         return `PIPF_MASK_FULL;
   endfunction : levelMask

   function automatic logic [17:0] divMinusOne(input logic [2:0] code);
      logic [17:0] m;
      m = `PIPF_DIV_M1_0;
      case (code)
         3'h0: m = `PIPF_DIV_M1_0;
         3'h1: m = `PIPF_DIV_M1_1;
         3'h2: m = `PIPF_DIV_M1_2;
         3'h3: m = `PIPF_DIV_M1_3;
         3'h4: m = `PIPF_DIV_M1_4;
         3'h5: m = `PIPF_DIV_M1_5;
         3'h6: m = `PIPF_DIV_M1_6;
         default: m = `PIPF_DIV_M1_7;
      endcase
      return m;
   endfunction : divMinusOne

   localparam pipf_pullup_kind_t PU_KIND =
      (PORT_ID inside {PIPF_PORT_1, PIPF_PORT_2, PIPF_PORT_3, PIPF_PORT_6, PIPF_PORT_9}) ? PIPF_PU_PLAIN :
      (PORT_ID inside {PIPF_PORT_B, PIPF_PORT_C, PIPF_PORT_D, PIPF_PORT_F, PIPF_PORT_H}) ? PIPF_PU_COMPAT :
      PIPF_PU_NONE;
   localparam logic HAS_LATCH = PORT_ID inside {PIPF_PORT_A, PIPF_PORT_B, PIPF_PORT_C, PIPF_PORT_D,
      PIPF_PORT_F, PIPF_PORT_G, PIPF_PORT_H};
   localparam logic HAS_FILTER = PORT_ID inside {PIPF_PORT_4, PIPF_PORT_6, PIPF_PORT_C, PIPF_PORT_G};
   localparam logic HAS_DIR = !(PORT_ID inside {PIPF_PORT_7, PIPF_PORT_E});
   localparam logic LEVEL_NEEDS_COMPAT = PORT_ID inside {PIPF_PORT_1, PIPF_PORT_2, PIPF_PORT_3,
      PIPF_PORT_4, PIPF_PORT_5, PIPF_PORT_6, PIPF_PORT_7, PIPF_PORT_8, PIPF_PORT_9};
   localparam logic [7:0] LEVEL_MASK = levelMask(PORT_ID);
   localparam logic [7:0] PULLUP_MASK = (PU_KIND == PIPF_PU_NONE) ? 8'h00 :
      (PORT_ID inside {PIPF_PORT_9, PIPF_PORT_H}) ? `PIPF_MASK_TOP2_RSVD : `PIPF_MASK_FULL;
   localparam logic [7:0] LATCH_MASK = !HAS_LATCH ? 8'h00 :
      (PORT_ID == PIPF_PORT_H) ? `PIPF_MASK_TOP2_RSVD : `PIPF_MASK_FULL;
   localparam logic [7:0] DIR_MASK = HAS_DIR ? LEVEL_MASK : 8'h00;
   localparam logic [7:0] FILTER_MASK = HAS_FILTER ? `PIPF_MASK_FULL : 8'h00;

   // ==========================================
   // registers
   logic [7:0] pullupCtrl;
   logic [7:0] outputLatch;
   logic [7:0] direction;
   logic [7:0] filterEnable;
   logic [7:0] filterExpect;
   logic [2:0] samplePeriod;
   logic [7:0] syncA;
   logic [7:0] syncB;
   logic [7:0] syncC;
   logic [7:0] pinLevel;
   logic [7:0] filtered;
   logic [7:0] lastSample;
   logic [7:0] inputLevel;
   logic [17:0] prescale;
   logic sampleTick;
   logic writeStrobe;
   logic addrHit;
   logic [31:0] readValue;
   logic [7:0] next_pullupOn;

   assign writeStrobe = psel && penable && pwrite;
   assign pready = 1'b1;

   // ==========================================
   // APB writes; the input-level offset takes writes silently
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pullupCtrl <= `PIPF_RST_PULLUP_CTRL;
         outputLatch <= `PIPF_RST_OUTPUT_LATCH;
         direction <= `PIPF_RST_DIRECTION;
         filterEnable <= `PIPF_RST_FILTER_ENABLE;
         filterExpect <= `PIPF_RST_FILTER_EXPECT;
         samplePeriod <= `PIPF_RST_SAMPLE_PERIOD;
      end
      else if (writeStrobe)
      begin
         if (paddr == `PIPF_OFS_PULLUP_CTRL)
            pullupCtrl <= pwdata[7:0] & PULLUP_MASK;
         else if (paddr == `PIPF_OFS_OUTPUT_LATCH)
            outputLatch <= pwdata[7:0] & LATCH_MASK;
         else if (paddr == `PIPF_OFS_DIRECTION)
            direction <= pwdata[7:0] & DIR_MASK;
         else if (paddr == `PIPF_OFS_FILTER_ENABLE)
            filterEnable <= pwdata[7:0] & FILTER_MASK;
         else if (paddr == `PIPF_OFS_FILTER_EXPECT)
            filterExpect <= pwdata[7:0] & FILTER_MASK;
         else if (paddr == `PIPF_OFS_SAMPLE_PERIOD && HAS_FILTER)
            samplePeriod <= pwdata[2:0];
      end
   end

   // ==========================================
   // APB reads: decoded in the setup cycle and held in a flop for the access cycle,
   // so read data is registered and still needs no wait state
   always_comb
   begin
      readValue = 32'h0000_0000;
      addrHit = 1'b1;
      if (paddr == `PIPF_OFS_INPUT_LEVEL)
         readValue[7:0] = inputLevel;
      else if (paddr == `PIPF_OFS_PULLUP_CTRL)
         readValue[7:0] = pullupCtrl;
      else if (paddr == `PIPF_OFS_OUTPUT_LATCH)
         readValue[7:0] = outputLatch;
      else if (paddr == `PIPF_OFS_DIRECTION)
         readValue[7:0] = direction;
      else if (paddr == `PIPF_OFS_FILTER_ENABLE)
         readValue[7:0] = filterEnable;
      else if (paddr == `PIPF_OFS_FILTER_EXPECT)
         readValue[7:0] = filterExpect;
      else if (paddr == `PIPF_OFS_SAMPLE_PERIOD)
         readValue[2:0] = samplePeriod;
      else
         addrHit = 1'b0;
      pslverr = psel && penable && !addrHit;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         prdata <= 32'h0000_0000;
      else if (psel && !penable)
         prdata <= readValue;
   end

   // ==========================================
   // pin synchroniser: a change counts once the second and third stages agree
   always_ff @(posedge clk)
   begin
      syncA <= pinIn;
      syncB <= syncA;
      syncC <= syncB;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         pinLevel <= 8'h00;
      else
         pinLevel <= (syncB & ~(syncB ^ syncC)) | (pinLevel & (syncB ^ syncC));
   end

   // ==========================================
   // sampling divider; free-running so a period change takes effect at once, ticking when the new low bits next read all ones
   assign sampleTick = (prescale & divMinusOne(samplePeriod)) == divMinusOne(samplePeriod);

   always_ff @(posedge clk)
   begin
      if (reset)
         prescale <= 18'h00000;
      else
         prescale <= prescale + 18'h00001;
   end

   // ==========================================
   // noise canceller per pin
   genvar b;
   generate
      for (b = 0; b < 8; b++)
      begin : g_filter
         always_ff @(posedge clk)
         begin
            if (reset)
            begin
               lastSample[b] <= 1'b0;
               filtered[b] <= 1'b0;
            end
            else if (!filterEnable[b])
            begin
               // bypass tracks the pin so enabling starts from the present level
               lastSample[b] <= pinLevel[b];
               filtered[b] <= pinLevel[b];
            end
            else if (sampleTick)
            begin
               lastSample[b] <= pinLevel[b];
               if (pinLevel[b] != filterExpect[b])
                  filtered[b] <= pinLevel[b];
               else if (lastSample[b] == pinLevel[b])
                  filtered[b] <= pinLevel[b];
            end
         end
      end
   endgenerate

   // level register shows the filtered pins; ports 1 to 9 need the compatibility select
   assign inputLevel = (LEVEL_NEEDS_COMPAT && !portControlTwo) ? 8'h00 : (filtered & LEVEL_MASK);

   // ==========================================
   // pull-up control and pin drive
   always_comb
   begin
      next_pullupOn = 8'h00;
      if (PU_KIND == PIPF_PU_PLAIN)
         next_pullupOn = ~direction & pullupCtrl;
      else if (PU_KIND == PIPF_PU_COMPAT && portControlTwo)
         next_pullupOn = ~direction & pullupCtrl;
      else if (PU_KIND == PIPF_PU_COMPAT)
         next_pullupOn = ~direction & outputLatch & PULLUP_MASK;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         pullupOn <= 8'h00;
         pinOut <= 8'h00;
         pinOe <= 8'h00;
      end
      else
      begin
         pullupOn <= next_pullupOn;
         pinOut <= outputLatch;
         pinOe <= direction;
      end
   end

   // ==========================================
   // checks
   property p_levelReadOnly;
      @(posedge clk) disable iff (reset)
      (writeStrobe && paddr == `PIPF_OFS_INPUT_LEVEL) |=>
         $stable(pullupCtrl) && $stable(outputLatch) && $stable(direction) && $stable(filterEnable);
   endproperty
   a_levelReadOnly: assert property (p_levelReadOnly) else $error("write to level register changed state");

   property p_levelRead;
      @(posedge clk) disable iff (reset)
      (psel && !penable && paddr == `PIPF_OFS_INPUT_LEVEL && (!LEVEL_NEEDS_COMPAT || portControlTwo))
         |=> prdata[7:0] == ($past(filtered) & LEVEL_MASK) && prdata[31:8] == 24'h000000;
   endproperty
   a_levelRead: assert property (p_levelRead) else $error("level read does not show pins");

   property p_levelCompat;
      @(posedge clk) disable iff (reset)
      (psel && !penable && LEVEL_NEEDS_COMPAT && !portControlTwo && paddr == `PIPF_OFS_INPUT_LEVEL)
         |=> prdata == 32'h0000_0000;
   endproperty
   a_levelCompat: assert property (p_levelCompat) else $error("level valid without select");

   property p_pullupOffOutput;
      @(posedge clk) disable iff (reset)
      ($past(direction) != 8'h00) |-> (pullupOn & $past(direction)) == 8'h00;
   endproperty
   a_pullupOffOutput: assert property (p_pullupOffOutput) else $error("pull-up on an output pin");

   property p_pullupReserved;
      @(posedge clk) disable iff (reset)
      (pullupCtrl & ~PULLUP_MASK) == 8'h00 && (outputLatch & ~LATCH_MASK) == 8'h00;
   endproperty
   a_pullupReserved: assert property (p_pullupReserved) else $error("reserved bit set");

   property p_pullupCompat;
      @(posedge clk) disable iff (reset)
      (PU_KIND == PIPF_PU_COMPAT && !portControlTwo) ##1 (PU_KIND == PIPF_PU_COMPAT)
         |-> pullupOn == (~$past(direction) & $past(outputLatch) & PULLUP_MASK);
   endproperty
   a_pullupCompat: assert property (p_pullupCompat) else $error("pull-up ignores latch in select 0");

   property p_pullupPcr;
      @(posedge clk) disable iff (reset)
      (PU_KIND == PIPF_PU_PLAIN || (PU_KIND == PIPF_PU_COMPAT && portControlTwo))
         |=> pullupOn == (~$past(direction) & $past(pullupCtrl));
   endproperty
   a_pullupPcr: assert property (p_pullupPcr) else $error("pull-up does not follow control");

   property p_pullupReset;
      @(posedge clk) reset |=> pullupOn == 8'h00 && pinOe == 8'h00 && pinOut == 8'h00;
   endproperty
   a_pullupReset: assert property (p_pullupReset) else $error("outputs not cleared by reset");

   property p_latchDrive;
      @(posedge clk) disable iff (reset)
      (writeStrobe && paddr == `PIPF_OFS_OUTPUT_LATCH) |=> ##1 pinOut == ($past(pwdata[7:0], 2) & LATCH_MASK);
   endproperty
   a_latchDrive: assert property (p_latchDrive) else $error("latch write not driven on pins");

   property p_bypass;
      @(posedge clk) disable iff (reset)
      (filterEnable == 8'h00) ##1 (filterEnable == 8'h00) |-> filtered == $past(pinLevel);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypassed pin not passed through");

   property p_holdBetweenTicks;
      @(posedge clk) disable iff (reset)
      !sampleTick ##1 ($past(filterEnable) == filterEnable) |-> ((filtered ^ $past(filtered)) & filterEnable) == 8'h00;
   endproperty
   a_holdBetweenTicks: assert property (p_holdBetweenTicks) else $error("filtered bit moved off tick");

   property p_expectStable;
      @(posedge clk) disable iff (reset)
      (sampleTick && filterEnable[0] && pinLevel[0] == filterExpect[0] && lastSample[0] != pinLevel[0]
         && filtered[0] != pinLevel[0]) |=> filtered[0] == $past(filtered[0]);
   endproperty
   a_expectStable: assert property (p_expectStable) else $error("expected level stored unstable");

   property p_dirWrite;
      @(posedge clk) disable iff (reset)
      (writeStrobe && paddr == `PIPF_OFS_DIRECTION) |=> direction == ($past(pwdata[7:0]) & DIR_MASK);
   endproperty
   a_dirWrite: assert property (p_dirWrite) else $error("direction write lost");

   property p_enableWrite;
      @(posedge clk) disable iff (reset)
      (writeStrobe && paddr == `PIPF_OFS_FILTER_ENABLE) |=> filterEnable == ($past(pwdata[7:0]) & FILTER_MASK);
   endproperty
   a_enableWrite: assert property (p_enableWrite) else $error("filter enable write lost");

   property p_expectWrite;
      @(posedge clk) disable iff (reset)
      (writeStrobe && paddr == `PIPF_OFS_FILTER_EXPECT) |=> filterExpect == ($past(pwdata[7:0]) & FILTER_MASK);
   endproperty
   a_expectWrite: assert property (p_expectWrite) else $error("expected level write lost");

   property p_samplePeriodWrite;
      @(posedge clk) disable iff (reset)
      (writeStrobe && paddr == `PIPF_OFS_SAMPLE_PERIOD && HAS_FILTER) |=> samplePeriod == $past(pwdata[2:0]);
   endproperty
   a_samplePeriodWrite: assert property (p_samplePeriodWrite) else $error("sampling code write lost");

   property p_oeFollows;
      @(posedge clk) disable iff (reset)
      pinOe == $past(direction);
   endproperty
   a_oeFollows: assert property (p_oeFollows) else $error("pin drive does not follow direction");

endmodule : pipf_port

// >>> bench/pipf_pin_model.sv
// external circuitry on the eight port pins, including the pull-up and floating levels
`timescale 1ns/100ps

module pipf_pin_model
(
   input wire logic clk,
   input wire logic [7:0] pinOut,
   input wire logic [7:0] pinOe,
   input wire logic [7:0] pullupOn,
   input wire logic [7:0] extDrive,
   input wire logic [7:0] extLevel,
   output logic [7:0] pinIn
);
   // ==========================================
   // floating pins
   // an undriven pin without pull-up toggles every clock, so the port's synchroniser never settles and keeps the last settled level
   logic [7:0] wander = 8'h00;

   always @(posedge clk)
      wander <= ~wander;

   // ==========================================
   // pin resolution
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (pinOe[i])
            pinIn[i] = pinOut[i];
         else if (extDrive[i])
            pinIn[i] = extLevel[i];
         else if (pullupOn[i])
            pinIn[i] = 1'b1;
         else
            pinIn[i] = wander[i];
      end
   end
endmodule : pipf_pin_model

// >>> bench/port_input_pullup_noise_filter_tb_top.sv
// testbench for the port block: registers, pin drive, pull-ups and noise filter
`timescale 1ns/100ps
`include "pipf_defs.svh"

module port_input_pullup_noise_filter_tb_top
   import pipf_pkg::*;
;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, portControlTwo, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdq;
   logic [7:0] pinIn, pinOut, pinOe, pullupOn, extDrive, extLevel;
   int errTotal = 0;
   int checks = 0;

   pipf_port i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .portControlTwo(portControlTwo),
      .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn));

   pipf_pin_model i_pins (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn), .extDrive(extDrive),
      .extLevel(extLevel), .pinIn(pinIn));

   // ==========================================
   // shared tasks
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rdq = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errTotal++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd(input logic [11:0] a, input logic [31:0] mask, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rdq & mask, exp);
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // ==========================================
   // scenarios
   task automatic t_reset_values;
      logic [11:0] ofs [4] = '{`PIPF_OFS_PULLUP_CTRL, `PIPF_OFS_OUTPUT_LATCH, `PIPF_OFS_FILTER_ENABLE,
         `PIPF_OFS_FILTER_EXPECT};
      chk({8'h00, pullupOn, pinOe, pinOut}, 32'h0);
      rd(`PIPF_OFS_DIRECTION, 32'hFFFFFFFF, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         rd(ofs[i], 32'hFFFFFFFF, 32'h0);
         apb(1'b1, ofs[i], 32'hFFFFFF5A);
         rd(ofs[i], 32'hFFFFFFFF, 32'h5A);
         apb(1'b1, ofs[i], 32'h0);
      end
      rd(`PIPF_OFS_SAMPLE_PERIOD, 32'hFFFFFFFF, 32'h0);
      apb(1'b1, `PIPF_OFS_SAMPLE_PERIOD, 32'hFFFFFFFF);
      rd(`PIPF_OFS_SAMPLE_PERIOD, 32'hFFFFFFFF, 32'h7);
      apb(1'b1, `PIPF_OFS_SAMPLE_PERIOD, 32'h0);
   endtask : t_reset_values

   task automatic t_input_level;
      extDrive <= 8'hFF;
      extLevel <= 8'hA5;
      cyc(8);
      rd(`PIPF_OFS_INPUT_LEVEL, 32'hFFFFFFFF, 32'hA5);
      apb(1'b1, `PIPF_OFS_INPUT_LEVEL, 32'h5A);
      chk({31'h0, rerr}, 32'h0);
      rd(`PIPF_OFS_INPUT_LEVEL, 32'hFFFFFFFF, 32'hA5);
      apb(1'b0, 12'h01C, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk(rdq, 32'h0);
   endtask : t_input_level

   task automatic t_output_drive;
      apb(1'b1, `PIPF_OFS_OUTPUT_LATCH, 32'h3C);
      apb(1'b1, `PIPF_OFS_DIRECTION, 32'hF0);
      cyc(3);
      chk({24'h0, pinOut}, 32'h3C);
      chk({24'h0, pinOe}, 32'hF0);
      cyc(6);
      rd(`PIPF_OFS_INPUT_LEVEL, 32'hFF, 32'h35);
   endtask : t_output_drive

   task automatic t_pullup;
      portControlTwo <= 1'b0;
      extDrive <= 8'h0F;
      apb(1'b1, `PIPF_OFS_DIRECTION, 32'h0F);
      apb(1'b1, `PIPF_OFS_OUTPUT_LATCH, 32'hFF);
      apb(1'b1, `PIPF_OFS_PULLUP_CTRL, 32'h33);
      cyc(3);
      chk({24'h0, pullupOn}, 32'hF0);
      portControlTwo <= 1'b1;
      apb(1'b1, `PIPF_OFS_OUTPUT_LATCH, 32'h00);
      cyc(3);
      chk({24'h0, pullupOn}, 32'h30);
      cyc(6);
      rd(`PIPF_OFS_INPUT_LEVEL, 32'h30, 32'h30);
      apb(1'b1, `PIPF_OFS_DIRECTION, 32'hFF);
      cyc(3);
      chk({24'h0, pullupOn}, 32'h00);
      apb(1'b1, `PIPF_OFS_DIRECTION, 32'h00);
      apb(1'b1, `PIPF_OFS_PULLUP_CTRL, 32'h00);
   endtask : t_pullup

   // bit 0 expects high, bit 1 expects low; a 17-cycle glitch spans two ticks only at the fast code
   task automatic t_filter(input logic [2:0] code, input logic [31:0] exp);
      extDrive <= 8'hFF;
      extLevel <= 8'h02;
      apb(1'b1, `PIPF_OFS_SAMPLE_PERIOD, {29'h0, code});
      apb(1'b1, `PIPF_OFS_FILTER_ENABLE, 32'h03);
      apb(1'b1, `PIPF_OFS_FILTER_EXPECT, 32'h01);
      cyc(80);
      rd(`PIPF_OFS_INPUT_LEVEL, 32'h07, 32'h02);
      extLevel <= 8'h05;
      cyc(10);
      rd(`PIPF_OFS_INPUT_LEVEL, 32'h07, exp);
      cyc(4);
      extLevel <= 8'h02;
      cyc(80);
   endtask : t_filter

   // ==========================================
   // run control
   task automatic close_out;
      if (errTotal == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   initial
   begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      portControlTwo = 1'b1;
      extDrive = 8'h00;
      extLevel = 8'h00;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_reset_values();
      t_input_level();
      t_output_drive();
      t_pullup();
      t_filter(3'h0, 32'h05);
      t_filter(3'h1, 32'h06);
      close_out();
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      errTotal++;
      close_out();
   end
endmodule : port_input_pullup_noise_filter_tb_top
